// ---- shared/sdctl_pkg.sv ----
package sdctl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_DELAY_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAL        = 8'h04;
  localparam logic [7:0] OFS_RDCFG      = 8'h08;

  // Field positions
  localparam int FB_LSB        = 8;
  localparam int FB_MSB        = 12;
  localparam int CMD_LSB       = 0;
  localparam int CMD_MSB       = 4;
  localparam int CAL_VAL_MSB   = 7;
  localparam int CAL_START_BIT = 14;
  localparam int CAL_DONE_BIT  = 15;
  localparam int RD_MSB        = 1;

  // Writable masks and reset values
  localparam logic [31:0] DELAY_CTRL_MASK = 32'h00001f1f;
  localparam logic [31:0] RDCFG_MASK      = 32'h00000003;
  localparam logic [31:0] DELAY_CTRL_RST  = 32'h00000000;
  localparam logic [31:0] RDCFG_RST       = 32'h00000000;
  localparam logic [7:0]  CAL_VAL_RST     = 8'h00;

  // Read configuration encodings
  localparam logic [1:0] RD_CLKOUT      = 2'h0;
  localparam logic [1:0] RD_CMD_DELAYED = 2'h1;

  // Time base figures
  localparam int TICK_PS       = 250;
  localparam int RING_OSC_KHZ  = 50000;
  localparam int REF_OSC_KHZ   = 12000;
  localparam int CLK_KHZ       = 40000;
  localparam int CLK_PERIOD_PS = 1000000000 / CLK_KHZ;

  // Calibration window in reference periods
  localparam int CAL_REF_PERIODS = 48;

  // Delay counts in ticks
  localparam int TICKS_W = 7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Calibration sequencer
  typedef enum logic [2:0] {
    CAL_IDLE  = 3'b001,
    CAL_RUN   = 3'b010,
    CAL_STORE = 3'b100
  } sdctl_cal_e;

endpackage

// ---- shared/sdctl_dly_if.sv ----
interface sdctl_dly_if;
  import sdctl_pkg::*;
  logic               start;
  logic [TICKS_W-1:0] ticks;
  logic               tick;
  logic               busy;
  logic               done;

  modport counter (input start, input ticks, input tick,
                   output busy, output done);
  modport user    (output start, output ticks, output tick,
                   input busy, input done);
endinterface

// ---- logic/sdctl_dly_cnt.sv ----
module sdctl_dly_cnt
  import sdctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Delay request
  sdctl_dly_if.counter dly
);

  logic [TICKS_W-1:0] remain;

  // Count oscillator ticks; a new start restarts the interval
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remain <= '0;
      dly.busy <= 1'b0;
      dly.done <= 1'b0;
    end else if (dly.start) begin
      remain <= dly.ticks;
      dly.busy <= 1'b1;
      dly.done <= 1'b0;
    end else if (dly.busy && dly.tick) begin
      remain <= remain - 7'h01;
      dly.done <= (remain == 7'h01);
      dly.busy <= (remain != 7'h01);
    end else begin
      dly.done <= 1'b0;
    end
  end

  // Busy after a start, done only ends a busy interval
  start_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dly.start |=> dly.busy)
    else $error("delay counter not busy after start");
  done_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dly.done |-> $past(dly.busy) && !dly.busy)
    else $error("delay done without busy interval");

endmodule

// ---- logic/sdctl_top.sv ----
// Function
// - Memory clock leaves and returns through a programmable feedback delay.
// - Command outputs launch from the returned feedback clock edge.
// - In command delay mode commands wait the programmed time after edge.
// - Both delay amounts are software registers outside the controller.
// - Both delay lines share the ring oscillator tick as time base.
// - Ring oscillator is calibrated against the 12 MHz reference.
// - Writing one to the start bit launches calibration.
// - Calibration result lands in bits 7..0 without software help.
// - Read data is captured relative to the fed back clock.
// - Feedback delay field is bits 12..8, quarter nanosecond steps.
// - More feedback delay moves the capture instant later.
// - Capture instant is command delay plus feedback delay in read mode one, feedback delay alone otherwise.
// - Read mode one delays all outputs except clock and enable.
// - Command delay field is bits 4..0, quarter nanosecond steps.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
module sdctl_top
  import sdctl_pkg::*;
#(
  parameter int AW        = 8,
  parameter int CMD_W     = 8,
  parameter int DATA_W    = 16,
  parameter int REF_COUNT = sdctl_pkg::CAL_REF_PERIODS
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [AW-1:0]     s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]     s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Oscillator ticks
  input  wire logic              ring_osc_tick,
  input  wire logic              ref_osc_tick,
  // Delay line settings
  output logic [4:0]             fb_delay_taps,
  output logic [4:0]             cmd_delay_taps,
  output logic                   cmd_delay_en,
  output logic [7:0]             cal_trim,
  output logic                   cal_busy,
  // Memory clock and feedback
  output logic                   memory_clock_output,
  input  wire logic              fb_clk_edge,
  // Commands from controller core
  input  wire logic [CMD_W-1:0]  cmd_in,
  input  wire logic              cke_in,
  output logic [CMD_W-1:0]       cmd_out,
  output logic                   cke_out,
  // Read data
  input  wire logic [DATA_W-1:0] rd_data_in,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_valid
);

  logic [31:0]      delay_line_control;
  logic [31:0]      dynamic_read_configuration;
  logic [7:0]       cal_value;
  logic             cal_done;
  sdctl_cal_e       cal_state;
  logic [7:0]       ref_cnt;
  logic [7:0]       ring_cnt;
  logic [AW-1:0]    aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             aw_held;
  logic             w_held;
  logic             wr_do;
  logic             cal_start_req;
  logic             cmd_mode;
  logic [CMD_W-1:0] cmd_hold;
  logic [4:0]       fb_field;
  logic [4:0]       cmd_field;

  sdctl_dly_if cmd_dly ();
  sdctl_dly_if cap_dly ();

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Address match on word offset
  function automatic logic hit(input logic [AW-1:0] addr,
                               input logic [7:0]    ofs);
    return addr[7:2] == ofs[7:2];
  endfunction

  // Register field views
  assign fb_field  = delay_line_control[FB_MSB:FB_LSB];
  assign cmd_field = delay_line_control[CMD_MSB:CMD_LSB];
  assign cmd_mode  = dynamic_read_configuration[RD_MSB:0] == RD_CMD_DELAYED;

  // Handshake readies
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do         = aw_held && w_held && !s_axi_bvalid;
  assign cal_start_req = wr_do && hit(aw_addr, OFS_CAL) && w_strb[1]
                         && w_data[CAL_START_BIT];

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      if (hit(aw_addr, OFS_DELAY_CTRL) || hit(aw_addr, OFS_CAL)
          || hit(aw_addr, OFS_RDCFG)) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software delay and mode registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_line_control         <= DELAY_CTRL_RST;
      dynamic_read_configuration <= RDCFG_RST;
    end else if (wr_do) begin
      if (hit(aw_addr, OFS_DELAY_CTRL)) begin
        delay_line_control <= merge(delay_line_control, w_data, w_strb,
                                    DELAY_CTRL_MASK);
      end else if (hit(aw_addr, OFS_RDCFG)) begin
        dynamic_read_configuration <= merge(dynamic_read_configuration,
                                            w_data, w_strb, RDCFG_MASK);
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (hit(s_axi_araddr, OFS_DELAY_CTRL)) begin
        s_axi_rdata <= delay_line_control;
      end else if (hit(s_axi_araddr, OFS_CAL)) begin
        s_axi_rdata <= {16'h0, cal_done, cal_state == CAL_RUN,
                        6'h00, cal_value};
      end else if (hit(s_axi_araddr, OFS_RDCFG)) begin
        s_axi_rdata <= dynamic_read_configuration;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Calibration sequencer: ring ticks per reference window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_state <= CAL_IDLE;
      ref_cnt   <= 8'h00;
      ring_cnt  <= 8'h00;
      cal_value <= CAL_VAL_RST;
      cal_done  <= 1'b0;
    end else begin
      case (cal_state)
        CAL_IDLE: begin
          if (cal_start_req) begin
            cal_state <= CAL_RUN;
            ref_cnt   <= 8'h00;
            ring_cnt  <= 8'h00;
            cal_done  <= 1'b0;
          end
        end
        CAL_RUN: begin
          if (ring_osc_tick && ring_cnt != 8'hff) begin
            ring_cnt <= ring_cnt + 8'h01;
          end
          if (ref_osc_tick) begin
            ref_cnt <= ref_cnt + 8'h01;
            if (ref_cnt == 8'(REF_COUNT - 1)) begin
              cal_state <= CAL_STORE;
            end
          end
        end
        CAL_STORE: begin
          cal_value <= ring_cnt;
          cal_done  <= 1'b1;
          cal_state <= CAL_IDLE;
        end
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  // Settings driven to the delay lines and oscillator trim
  assign fb_delay_taps  = fb_field;
  assign cmd_delay_taps = cmd_field;
  assign cmd_delay_en   = cmd_mode;
  assign cal_trim       = cal_value;
  assign cal_busy       = cal_state != CAL_IDLE;

  // Outgoing memory clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memory_clock_output <= 1'b0;
    end else begin
      memory_clock_output <= !memory_clock_output;
    end
  end

  // Delay requests timed by the shared ring tick
  assign cmd_dly.start = fb_clk_edge && cmd_mode;
  assign cmd_dly.ticks = {2'b00, cmd_field} + 7'h01;
  assign cmd_dly.tick  = ring_osc_tick;
  assign cap_dly.start = fb_clk_edge;
  assign cap_dly.ticks = cmd_mode ?
    {2'b00, cmd_field} + {2'b00, fb_field} + 7'h02 :
    {2'b00, fb_field} + 7'h01;
  assign cap_dly.tick  = ring_osc_tick;

  sdctl_dly_cnt u_cmd_dly (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dly     (cmd_dly)
  );

  sdctl_dly_cnt u_cap_dly (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dly     (cap_dly)
  );

  // Command launch from feedback edge, optionally delayed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_out  <= '0;
      cmd_hold <= '0;
      cke_out  <= 1'b0;
    end else begin
      if (fb_clk_edge) begin
        cke_out  <= cke_in;
        cmd_hold <= cmd_in;
        if (!cmd_mode) begin
          cmd_out <= cmd_in;
        end
      end
      if (cmd_dly.done && !fb_clk_edge) begin
        cmd_out <= cmd_hold;
      end
    end
  end

  // Read data capture at the delayed feedback instant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cap_dly.done;
      if (cap_dly.done) begin
        rd_data <= rd_data_in;
      end
    end
  end

  sequence cal_run_s;
    cal_state == CAL_RUN;
  endsequence

  sequence cal_store_s;
    cal_state == CAL_STORE ##1 cal_done;
  endsequence

  cal_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_state == CAL_IDLE && cal_start_req |=> cal_run_s)
    else $error("calibration did not start");
  cal_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_state == CAL_STORE |=> cal_value == $past(ring_cnt) && cal_done)
    else $error("calibration value not stored");
  cal_finish_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_state == CAL_RUN && ref_osc_tick && ref_cnt == 8'(REF_COUNT - 1)
    |=> cal_store_s)
    else $error("calibration window end missed");
  cmd_direct_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fb_clk_edge && !cmd_mode |=> cmd_out == $past(cmd_in))
    else $error("command not launched on feedback edge");
  cmd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !$stable(cmd_out) |-> $past(fb_clk_edge && !cmd_mode)
    || $past(cmd_dly.done))
    else $error("command changed outside launch instant");
  cke_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fb_clk_edge |=> cke_out == $past(cke_in))
    else $error("clock enable was delayed");
  fb_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && hit(aw_addr, OFS_DELAY_CTRL) && w_strb[1]
    |=> fb_delay_taps == $past(w_data[FB_MSB:FB_LSB]))
    else $error("feedback delay field not taken");
  cmd_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && hit(aw_addr, OFS_DELAY_CTRL) && w_strb[0]
    |=> cmd_delay_taps == $past(w_data[CMD_MSB:CMD_LSB]))
    else $error("command delay field not taken");
  cap_sum_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fb_clk_edge && cmd_mode
    |-> cap_dly.ticks == 7'(cmd_field) + 7'(fb_field) + 7'h02)
    else $error("capture delay is not the sum");
  cap_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cap_dly.done |=> rd_valid && rd_data == $past(rd_data_in))
    else $error("read data not captured");

endmodule

// ---- verif/sdctl_mem_model.sv ----
module sdctl_mem_model #(
  parameter int REF_DIV = 5
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Frame request from the bench
  input  wire logic        frame_req,
  // Returned clock edge and oscillators
  output logic             fb_clk_edge,
  output logic             ring_osc_tick,
  output logic             ref_osc_tick,
  // Read data from the memory
  output logic [15:0]      rd_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int ref_cnt;

  // Returned clock edge only inside a frame, still between frames
  always_ff @(posedge aclk) begin
    fb_clk_edge <= aresetn && frame_req;
  end

  // Ring tick each cycle, reference tick every REF_DIV cycles
  always_ff @(posedge aclk) begin
    ring_osc_tick <= aresetn;
    ref_osc_tick  <= aresetn && (ref_cnt == 0);
    if (!aresetn || ref_cnt == REF_DIV - 1) begin
      ref_cnt <= 0;
    end else begin
      ref_cnt <= ref_cnt + 1;
    end
  end

  // Data lines hold 16'h5a5a in reset, then take a new value every cycle
  always_ff @(posedge aclk) begin
    rd_data_in <= aresetn ? rd_data_in + 16'h3b1d : 16'h5a5a;
  end
endmodule

// ---- verif/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sdctl_pkg::*;
  localparam int RC = 4;
  localparam int RD = 5;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rv;
  logic        ring_tick, ref_tick, fb_edge, frame_req = 1'b0;
  logic [4:0]  fb_taps, cmd_taps;
  logic        cmd_en, cal_busy, mclk, cke_out, rd_valid;
  logic        cke_in  = 1'b0;
  logic [7:0]  cal_trim, cmd_out;
  logic [7:0]  cmd_in  = 8'h00;
  logic [15:0] rd_in, rd_data;
  logic [31:0] lfsr    = 32'hddaf43e2;
  logic [31:0] shadow [3];
  int          mismatches = 0;
  int          checks_done = 0;
  int          lat0, lat;
  int          fbs [2] = '{5, 31};
  int          cmds [2] = '{2, 20};

  // Free-running bench clock
  always #12.5 aclk = ~aclk;

  sdctl_top #(.REF_COUNT(RC)) i_sdctl_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ring_osc_tick(ring_tick), .ref_osc_tick(ref_tick),
    .fb_delay_taps(fb_taps), .cmd_delay_taps(cmd_taps),
    .cmd_delay_en(cmd_en), .cal_trim(cal_trim), .cal_busy(cal_busy),
    .memory_clock_output(mclk), .fb_clk_edge(fb_edge),
    .cmd_in(cmd_in), .cke_in(cke_in), .cmd_out(cmd_out), .cke_out(cke_out),
    .rd_data_in(rd_in), .rd_data(rd_data), .rd_valid(rd_valid));

  sdctl_mem_model #(.REF_DIV(RD)) i_sdctl_mem_model (
    .aclk(aclk), .aresetn(aresetn), .frame_req(frame_req),
    .fb_clk_edge(fb_edge), .ring_osc_tick(ring_tick),
    .ref_osc_tick(ref_tick), .rd_data_in(rd_in));

  // Random source
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("mismatch at %0t ns: %s", $time, msg);
    end
  endtask

  // Bus write: both channels offered, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aok, wok, bok;
    n = 0;
    bok = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    while (!bok && n < 100) begin
      @(negedge aclk);
      aok = awvalid && awready;
      wok = wvalid && wready;
      bok = bvalid === 1'b1;
      resp = bresp;
      @(posedge aclk);
      if (aok) awvalid <= 1'b0;
      if (wok) wvalid <= 1'b0;
      if (bok) bready <= 1'b0;
      n++;
    end
    chk(bok, "no write response");
  endtask

  // Bus read
  task automatic axi_rd(input logic [7:0] a);
    int n;
    bit aok, rok;
    n = 0;
    rok = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!rok && n < 100) begin
      @(negedge aclk);
      aok = arvalid && arready;
      rok = rvalid === 1'b1;
      rv = rdata;
      resp = rresp;
      @(posedge aclk);
      if (aok) arvalid <= 1'b0;
      if (rok) rready <= 1'b0;
      n++;
    end
    chk(rok, "no read response");
  endtask

  // Write and update the shadow copy
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] m;
    axi_wr(a, d);
    m = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    chk(resp === (a < 8'h0c ? RESP_OKAY : RESP_SLVERR), "write resp");
    if (a == OFS_DELAY_CTRL) begin
      shadow[0] = ((shadow[0] & ~m) | (d & m)) & DELAY_CTRL_MASK;
    end
    if (a == OFS_RDCFG) begin
      shadow[2] = ((shadow[2] & ~m) | (d & m)) & RDCFG_MASK;
    end
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic [31:0] m);
    axi_rd(a);
    chk(resp === RESP_OKAY && (rv & m) === (e & m), "register readback");
  endtask

  // One frame: returned edge, command launch and read capture
  task automatic frame(input bit dly, output int n);
    logic [31:0] v;
    logic [15:0] prev;
    logic [7:0]  old, cmd;
    bit          got;
    v = rnd();
    old = cmd_out;
    cmd = (v[7:0] == old) ? ~old : v[7:0];
    @(posedge aclk);
    cmd_in <= cmd; cke_in <= v[8]; frame_req <= 1'b1;
    @(posedge aclk);
    frame_req <= 1'b0;
    n = 0;
    got = 0;
    while (!got && n < 200) begin
      @(negedge aclk);
      n++;
      if (n == 2) chk(cke_out === v[8], "clock enable late");
      if (dly && n == 2) chk(cmd_out === old, "command early");
      if (rd_valid === 1'b1) begin
        got = 1;
        chk(rd_data === prev, "captured word");
        chk(cmd_out === cmd, "launched command");
      end
      prev = rd_in;
    end
    chk(got, "no read capture");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    shadow = '{default: 32'h0};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) reg_chk(8'(i * 4), 32'h0, '1);
    @(negedge aclk);
    rv[0] = mclk;
    @(negedge aclk);
    chk(mclk === ~rv[0], "memory clock idle");
    repeat (3) begin
      rv = rnd();
      wstrb <= rv[31:28]; // Random byte lanes on the delay register
      reg_wr(OFS_DELAY_CTRL, rv);
      reg_chk(OFS_DELAY_CTRL, shadow[0], '1);
      chk(fb_taps === shadow[0][12:8], "feedback taps");
      chk(cmd_taps === shadow[0][4:0], "command taps");
    end
    wstrb <= 4'hf;
    reg_wr(8'h0c, 32'hffffffff);
    axi_rd(8'h0c);
    chk(resp === RESP_SLVERR, "unmapped read");
    reg_chk(OFS_DELAY_CTRL, shadow[0], '1);
    for (int m = 3; m >= 0; m--) begin
      reg_wr(OFS_RDCFG, 32'(m));
      reg_chk(OFS_RDCFG, shadow[2], '1);
      chk(cmd_en === (m == 1), "read mode");
    end
    reg_wr(OFS_CAL, 32'h00004000);
    reg_chk(OFS_CAL, 32'h00004000, 32'h0000c000);
    lat = 0;
    while (cal_busy !== 1'b0 && lat < 500) begin
      @(negedge aclk);
      lat++;
    end
    // Delays are trusted only after calibration settles
    axi_rd(OFS_CAL);
    chk(rv[15] === 1'b1 && rv[7:0] === cal_trim, "calibration store");
    lat = int'(rv[7:0]);
    chk(lat >= (RC - 1) * RD && lat <= (RC + 1) * RD, "trim count");
    reg_wr(OFS_DELAY_CTRL, 32'h0);
    frame(1'b0, lat0);
    foreach (fbs[i]) begin
      reg_wr(OFS_DELAY_CTRL, 32'(fbs[i]) << 8);
      frame(1'b0, lat);
      chk(lat == lat0 + fbs[i], "feedback delay");
    end
    reg_wr(OFS_RDCFG, 32'h1);
    foreach (cmds[i]) begin
      reg_wr(OFS_DELAY_CTRL, (32'h3 << 8) | 32'(cmds[i]));
      frame(1'b1, lat);
      lat = lat - lat0 - 3 - cmds[i];
      chk(lat == 1, "capture instant");
    end
    tally_and_finish;
  end
endmodule
